// [design/irq_cond_top.sv]
// Interrupt source conditioner driving the processor irq and fiq outputs.
//
// Summary of operation
// R1 - Podule fast request is active low level, pending while held low.
// R2 - Podule normal request is active low level, pending while low.
// R3 - Serial controller request is active low level.
// R4 - SCSI controller request is active low level.
// R5 - Floppy controller request is active low level.
// R6 - Floppy index sets an event only on a falling edge.
// R7 - Video flyback sets an event on each rising edge.
// R8 - Floppy data request is an active high level fast request.
// R9 - Printer request sets an event only on a rising edge.
// R10 - Extended request is active low level.
// R11 - Drive fast output normally; sample that pin as test mode in reset.
// R12 - Mask register gates each request before the outputs.
// R13 - Keyboard serial interface can raise a request.
// R14 - Second processor request beats main memory request when both asserted.
// R15 - Edge events latch until software clears them.
// R16 - Outputs asserted low while any unmasked routed request is pending.
module irq_cond_top
    import irq_cond_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_podule_fiq_n,
    input wire logic i_podule_irq_n,
    input wire logic i_serial_irq_n,
    input wire logic i_scsi_irq_n,
    input wire logic i_floppy_irq_n,
    input wire logic i_floppy_index_n,
    input wire logic i_flyback,
    input wire logic i_floppy_drq,
    input wire logic i_printer_irq,
    input wire logic i_ext_irq_n,
    input wire logic i_kbd_irq,
    input wire logic i_second_req_n,
    input wire logic i_main_req_n,
    input wire logic [NUM_SRC-1:0] i_mask_wdata,
    input wire logic i_mask_we,
    input wire logic [NUM_SRC-1:0] i_clear,
    input wire logic i_fiq_pin,
    output logic o_fiq_n,
    output logic o_fiq_oe,
    output logic o_irq_n,
    output logic [NUM_SRC-1:0] o_pending,
    output logic [NUM_SRC-1:0] o_mask,
    output logic o_test_mode,
    output grant_t o_grant
);
    src_if sif();

    logic [NUM_SRC-1:0] pins;
    logic [NUM_SRC-1:0] sync;
    logic [NUM_SRC-1:0] mask_ff;
    logic [NUM_SRC-1:0] nxt_mask;
    logic [NUM_SRC-1:0] live;
    logic fiq_n_ff;
    logic irq_n_ff;
    logic nxt_fiq_n;
    logic nxt_irq_n;
    logic [NUM_SRC-1:0] pend_ff;
    logic tpin_meta_ff;
    logic tpin_sync_ff;
    logic test_ff;
    logic nxt_test;
    logic in_reset_ff;
    logic nxt_in_reset;
    grant_t grant_ff;
    grant_t nxt_grant;

    // Turn every pin except the floppy index into an active high request before synchronising.
    always_comb begin
        pins = '0;
        pins[SRC_PODULE_FAST] = ~i_podule_fiq_n; // R1
        pins[SRC_PODULE_NORM] = ~i_podule_irq_n; // R2
        pins[SRC_SERIAL] = ~i_serial_irq_n; // R3
        pins[SRC_SCSI] = ~i_scsi_irq_n; // R4
        pins[SRC_FLOPPY] = ~i_floppy_irq_n; // R5
        pins[SRC_INDEX] = i_floppy_index_n;
        pins[SRC_FLYBACK] = i_flyback;
        pins[SRC_FLOPPY_DRQ] = i_floppy_drq; // R8
        pins[SRC_PRINTER] = i_printer_irq;
        pins[SRC_EXTENDED] = ~i_ext_irq_n; // R10
        pins[SRC_KEYBOARD] = i_kbd_irq; // R13
        pins[SRC_COPROC] = 1'b0;
    end

    src_sync u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_pins(pins),
        .o_sync(sync)
    );

    assign sif.raw = sync;
    assign sif.clr = i_clear;

    src_cond u_cond (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .sif(sif)
    );

    // Mask register; a one lets the source through.
    always_comb begin
        nxt_mask = i_mask_we ? i_mask_wdata : mask_ff; // R12
        live = sif.active & mask_ff; // R12
        // Outputs are registered so the pins never glitch on decode.
        nxt_fiq_n = ~|(live & FAST_ROUTE); // R16
        nxt_irq_n = ~|(live & ~FAST_ROUTE); // R16
    end

    // Test mode is caught from the shared fiq pin while reset is held,
    // using a clocked sampler because reset itself may only load constants.
    always_comb begin
        nxt_in_reset = 1'b0;
        nxt_test = in_reset_ff ? tpin_sync_ff : test_ff; // R11
    end

    // Arbitration: the second processor wins a simultaneous request.
    always_comb begin
        if (!i_second_req_n) begin
            nxt_grant = GRANT_SECOND; // R14
        end else if (!i_main_req_n) begin
            nxt_grant = GRANT_MAIN;
        end else begin
            nxt_grant = GRANT_NONE;
        end
    end

    // Main state registers.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mask_ff <= MASK_RESET;
            fiq_n_ff <= 1'b1;
            irq_n_ff <= 1'b1;
            pend_ff <= '0;
            in_reset_ff <= 1'b1;
            test_ff <= TEST_MODE_RESET;
            grant_ff <= GRANT_NONE;
        end else begin
            mask_ff <= nxt_mask;
            fiq_n_ff <= nxt_fiq_n;
            irq_n_ff <= nxt_irq_n;
            pend_ff <= sif.active;
            in_reset_ff <= nxt_in_reset;
            test_ff <= nxt_test;
            grant_ff <= nxt_grant;
        end
    end

    // Pin synchroniser for the test strap; runs through reset.
    always_ff @(posedge i_clk) begin
        tpin_meta_ff <= i_fiq_pin;
        tpin_sync_ff <= tpin_meta_ff;
    end

    // The fiq driver is released during reset so the strap can be read.
    assign o_fiq_oe = i_rst_n; // R11
    assign o_fiq_n = fiq_n_ff;
    assign o_irq_n = irq_n_ff;
    assign o_pending = pend_ff;
    assign o_mask = mask_ff;
    assign o_test_mode = test_ff;
    assign o_grant = grant_ff;
endmodule

// [design/irq_cond_pkg.sv]
// Constants and types shared by the interrupt source conditioner.
package irq_cond_pkg;
    // Number of conditioned interrupt sources.
    localparam int unsigned NUM_SRC = 12;
    // Source bit positions in the pending and mask vectors.
    localparam int unsigned SRC_PODULE_FAST = 0;
    localparam int unsigned SRC_PODULE_NORM = 1;
    localparam int unsigned SRC_SERIAL = 2;
    localparam int unsigned SRC_SCSI = 3;
    localparam int unsigned SRC_FLOPPY = 4;
    localparam int unsigned SRC_INDEX = 5;
    localparam int unsigned SRC_FLYBACK = 6;
    localparam int unsigned SRC_FLOPPY_DRQ = 7;
    localparam int unsigned SRC_PRINTER = 8;
    localparam int unsigned SRC_EXTENDED = 9;
    localparam int unsigned SRC_KEYBOARD = 10;
    localparam int unsigned SRC_COPROC = 11;
    // Sources that are edge events and latch a pending flag.
    localparam logic [11:0] EDGE_SRC_MASK = 12'h160;
    // Sources that are routed to the fast output; the rest go normal.
    localparam logic [11:0] FAST_ROUTE = 12'h081;
    // Mask reset value: all sources blocked until software enables them.
    localparam logic [11:0] MASK_RESET = 12'h000;
    // Polarity-adjusted idle level of each source; the index pin rests high.
    localparam logic [11:0] PIN_IDLE = 12'h020;
    // Sampled test mode reset value.
    localparam logic TEST_MODE_RESET = 1'b0;
    // Bus arbitration grant encoding.
    typedef enum logic [1:0] {
        GRANT_NONE = 2'b00,
        GRANT_MAIN = 2'b01,
        GRANT_SECOND = 2'b10
    } grant_t;
endpackage

// [design/src_if.sv]
// Interface carrying raw and conditioned source vectors between modules.
interface src_if;
    import irq_cond_pkg::*;
    logic [NUM_SRC-1:0] raw;
    logic [NUM_SRC-1:0] active;
    logic [NUM_SRC-1:0] clr;
    modport producer(input raw, input clr, output active);
    modport consumer(output raw, output clr, input active);
endinterface

// [design/src_sync.sv]
// Two-stage synchroniser for the interrupt pins.
module src_sync
    import irq_cond_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [NUM_SRC-1:0] i_pins,
    output logic [NUM_SRC-1:0] o_sync
);
    logic [NUM_SRC-1:0] meta_ff;
    logic [NUM_SRC-1:0] sync_ff;
    logic [NUM_SRC-1:0] nxt_meta;
    logic [NUM_SRC-1:0] nxt_sync;

    // The first stage only feeds the second one.
    always_comb begin
        nxt_meta = i_pins;
        nxt_sync = meta_ff;
    end

    // Reset to each pin's idle level so release does not look like an edge.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_ff <= PIN_IDLE;
            sync_ff <= PIN_IDLE;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign o_sync = sync_ff;
endmodule

// [design/src_cond.sv]
// Per-source level and edge conditioning with sticky edge flags.
module src_cond
    import irq_cond_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    src_if.producer sif
);
    logic [NUM_SRC-1:0] prev_ff;
    logic [NUM_SRC-1:0] latch_ff;
    logic [NUM_SRC-1:0] nxt_prev;
    logic [NUM_SRC-1:0] nxt_latch;
    logic [NUM_SRC-1:0] rise;
    logic [NUM_SRC-1:0] fall;
    logic [NUM_SRC-1:0] ev;

    // Edge detect on synchronised, already polarity-adjusted inputs.
    always_comb begin
        nxt_prev = sif.raw;
        rise = sif.raw & ~prev_ff;
        fall = ~sif.raw & prev_ff;
        ev = '0;
        ev[SRC_INDEX] = fall[SRC_INDEX]; // R6
        ev[SRC_FLYBACK] = rise[SRC_FLYBACK]; // R7
        ev[SRC_PRINTER] = rise[SRC_PRINTER]; // R9
        // A new event wins over a clear in the same cycle.
        nxt_latch = ((latch_ff & ~sif.clr) | ev) & EDGE_SRC_MASK; // R15
    end

    // Previous sample resets to the idle level, as the synchroniser does.
    // A pin held active through reset shows one edge at release.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_ff <= PIN_IDLE;
            latch_ff <= '0;
        end else begin
            prev_ff <= nxt_prev;
            latch_ff <= nxt_latch;
        end
    end

    // Edge sources report the latch; level sources report the pin itself.
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_sel
            if (EDGE_SRC_MASK[g]) begin : g_edge
                assign sif.active[g] = latch_ff[g];
            end else begin : g_lvl
                assign sif.active[g] = sif.raw[g];
            end
        end
    endgenerate
endmodule

// [testbench/irq_cond_props.sv]
// Concurrent checks on the interrupt source conditioner ports.
module irq_cond_props
    import irq_cond_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_serial_irq_n,
    input wire logic i_floppy_index_n,
    input wire logic i_floppy_drq,
    input wire logic i_second_req_n,
    input wire logic [NUM_SRC-1:0] i_mask_wdata,
    input wire logic i_mask_we,
    input wire logic [NUM_SRC-1:0] i_clear,
    input wire logic o_fiq_n,
    input wire logic o_irq_n,
    input wire logic [NUM_SRC-1:0] o_pending,
    input wire logic [NUM_SRC-1:0] o_mask,
    input wire logic o_test_mode,
    input wire grant_t o_grant
);
    timeunit 1ns;
    timeprecision 1ns;
    // Five samples cover the two sync stages with margin after reset.
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    a_serial_level: assert property (
        !i_serial_irq_n [*5] |-> o_pending[SRC_SERIAL])
        else $error("serial request not pending");
    a_drq_level: assert property (
        i_floppy_drq [*5] |-> o_pending[SRC_FLOPPY_DRQ])
        else $error("data request not pending");
    a_index_no_level: assert property (
        $stable(i_floppy_index_n) [*6] ##0 !o_pending[SRC_INDEX]
        |=> !o_pending[SRC_INDEX])
        else $error("index flag set without an edge");
    a_flag_holds: assert property (
        o_pending[SRC_FLYBACK] && !i_clear[SRC_FLYBACK]
        && !$past(i_clear[SRC_FLYBACK]) |=> o_pending[SRC_FLYBACK])
        else $error("flyback flag dropped without a clear");
    a_fiq_asserts: assert property (
        ((o_pending & $past(o_mask) & FAST_ROUTE) != 12'h000) |-> !o_fiq_n)
        else $error("fast output not asserted");
    a_irq_release: assert property (
        ((o_pending & $past(o_mask) & ~FAST_ROUTE) == 12'h000) |-> o_irq_n)
        else $error("normal output asserted with nothing pending");
    a_mask_load: assert property (
        i_mask_we |=> o_mask == $past(i_mask_wdata))
        else $error("mask not loaded");
    a_grant_second: assert property (
        !i_second_req_n |=> o_grant == GRANT_SECOND)
        else $error("second requester not granted");
    a_test_hold: assert property (
        $past(i_rst_n) && $past(i_rst_n, 2) |-> $stable(o_test_mode))
        else $error("test mode changed outside reset");
endmodule

bind irq_cond_top irq_cond_props u_props (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_serial_irq_n(i_serial_irq_n),
    .i_floppy_index_n(i_floppy_index_n),
    .i_floppy_drq(i_floppy_drq),
    .i_second_req_n(i_second_req_n),
    .i_mask_wdata(i_mask_wdata),
    .i_mask_we(i_mask_we),
    .i_clear(i_clear),
    .o_fiq_n(o_fiq_n),
    .o_irq_n(o_irq_n),
    .o_pending(o_pending),
    .o_mask(o_mask),
    .o_test_mode(o_test_mode),
    .o_grant(o_grant)
);

// [testbench/cpu_irq_model.sv]
// Processor side model that counts fast and normal interrupt entries.
module cpu_irq_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_fiq_n,
    input wire logic i_irq_n,
    output int o_fiq_cnt,
    output int o_irq_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic fiq_d, irq_d;
    // The core samples its lines on the clock, so a glitch between edges is not an entry.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {fiq_d, irq_d} <= 2'h3;
            {o_fiq_cnt, o_irq_cnt} <= '0;
        end else begin
            {fiq_d, irq_d} <= {i_fiq_n, i_irq_n};
            o_fiq_cnt <= o_fiq_cnt + int'(fiq_d && !i_fiq_n);
            o_irq_cnt <= o_irq_cnt + int'(irq_d && !i_irq_n);
        end
    end
endmodule

// [testbench/tb.sv]
// Bench for the interrupt source conditioner and its processor model.
module tb
    import irq_cond_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rst_n, sec_n, main_n, mask_we, strap;
    logic [11:0] src, mask_wd, clr, pend, msk;
    logic fiq_n, fiq_oe, irq_n, tmode;
    grant_t grant;
    int miscompares, checks, fiq_cnt, irq_cnt;
    // Strap resistor holds the fast line while the device lets go.
    wire fiq_wire = fiq_oe ? fiq_n : strap;
    irq_cond_top u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_podule_fiq_n(~src[0]), .i_podule_irq_n(~src[1]),
        .i_serial_irq_n(~src[2]), .i_scsi_irq_n(~src[3]),
        .i_floppy_irq_n(~src[4]), .i_floppy_index_n(~src[5]),
        .i_flyback(src[6]), .i_floppy_drq(src[7]),
        .i_printer_irq(src[8]), .i_ext_irq_n(~src[9]),
        .i_kbd_irq(src[10]), .i_second_req_n(sec_n),
        .i_main_req_n(main_n), .i_mask_wdata(mask_wd),
        .i_mask_we(mask_we), .i_clear(clr), .i_fiq_pin(fiq_wire),
        .o_fiq_n(fiq_n), .o_fiq_oe(fiq_oe), .o_irq_n(irq_n),
        .o_pending(pend), .o_mask(msk), .o_test_mode(tmode),
        .o_grant(grant));
    cpu_irq_model u_cpu (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_fiq_n(fiq_wire), .i_irq_n(irq_n), .o_fiq_cnt(fiq_cnt),
        .o_irq_cnt(irq_cnt));
    // Free-running 20 MHz clock.
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    task automatic cmp(input string what, input logic [11:0] exp,
            input logic [11:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Inputs move 5 ns after the edge so sampling never races them.
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #5;
    endtask
    task report_and_stop();
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Each level source in turn, outputs routed by the fast map.
    task automatic t_level();
        for (int s = 0; s < 11; s++) begin
            if (EDGE_SRC_MASK[s]) continue;
            src[s] = 1'b1;
            step(6);
            cmp("pend", 12'h001 << s, pend);
            cmp("outs", FAST_ROUTE[s] ? 12'h001 : 12'h002,
                {10'h0, fiq_n, irq_n});
            src[s] = 1'b0;
            step(6);
            cmp("idle", 12'h003, {pend[9:0], fiq_n, irq_n});
        end
    endtask
    // A short pulse latches; a held level or the other edge does not.
    task automatic t_edge();
        for (int s = 0; s < 11; s++) begin
            if (!EDGE_SRC_MASK[s]) continue;
            src[s] = 1'b1;
            step(2);
            src[s] = 1'b0;
            step(8);
            cmp("edge pend", 12'h001 << s, pend);
            cmp("edge outs", 12'h002, {10'h0, fiq_n, irq_n});
            src[s] = 1'b1;
            step(6);
            clr[s] = 1'b1;
            step(1);
            clr[s] = 1'b0;
            step(6);
            cmp("edge clear", 12'h000, pend);
            src[s] = 1'b0;
            step(6);
            cmp("wrong edge", 12'h000, pend);
        end
    endtask
    // Reset with a strap level; a strap equal to the idle output level
    // could not tell sampling in reset from sampling after it.
    task automatic t_reset(input logic lvl);
        i_rst_n = 1'b0;
        strap = lvl;
        step(3);
        cmp("fiq oe low", 12'h000, {11'h0, fiq_oe});
        i_rst_n = 1'b1;
        step(2);
        cmp("fiq oe", 12'h001, {11'h0, fiq_oe});
        cmp("test mode", {11'h0, lvl}, {11'h0, tmode});
        cmp("mask", MASK_RESET, msk);
        cmp("pend reset", 12'h000, pend);
        cmp("outs reset", 12'h003, {10'h0, fiq_n, irq_n});
    endtask
    // A request stays off the outputs until its mask bit is set.
    task automatic t_mask();
        src[SRC_SERIAL] = 1'b1;
        step(6);
        cmp("masked irq", 12'h001, {11'h0, irq_n});
        mask_wd = 12'hfff;
        mask_we = 1'b1;
        step(1);
        mask_we = 1'b0;
        step(3);
        cmp("unmasked irq", 12'h000, {11'h0, irq_n});
        cmp("mask value", 12'hfff, msk);
        src = 12'h000;
        step(6);
    endtask
    // Second requester beats the main one when both ask.
    task automatic t_grant();
        {sec_n, main_n} = 2'b00;
        step(2);
        cmp("grant both", {10'h0, GRANT_SECOND}, {10'h0, grant});
        sec_n = 1'b1;
        step(2);
        cmp("grant main", {10'h0, GRANT_MAIN}, {10'h0, grant});
        main_n = 1'b1;
        step(2);
        cmp("grant none", {10'h0, GRANT_NONE}, {10'h0, grant});
    endtask
    // Every separate assertion of a line is one entry at the processor.
    task automatic t_entries();
        cmp("fiq entries", 12'h002, fiq_cnt[11:0]);
        cmp("irq entries", 12'h00a, irq_cnt[11:0]);
    endtask
    // Scenario sequence; the closing reset uses the other strap level.
    initial begin
        {sec_n, main_n} = 2'b11;
        {src, mask_wd, clr, mask_we} = '0;
        t_reset(1'b1);
        t_mask();
        t_level();
        t_edge();
        t_grant();
        t_entries();
        t_reset(1'b0);
        report_and_stop();
    end
    // The run needs under 1000 cycles; cut any hang short.
    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end
endmodule
